// File: seq_i2c_slave.v
`timescale 1ns/1ps
`include "seq_i2c_map.vh"
module seq_i2c_slave #(
  parameter POWERUP_CYCLES = `POWERUP_DELAY_NS / `CLK_PERIOD_NS,
  parameter CNT_W          = 20
) (
  input  wire       sys_clk_in,
  input  wire       rstn_in,
  input  wire       scl_in,
  input  wire       sda_in,
  input  wire       addr_strap_high_in,
  input  wire       addr_strap_low_in,
  output reg        sda_out,
  output reg        sda_oe_out,
  output reg        busy_out,
  output reg  [7:0] polarity_out
);
  localparam NV_WR_CYCLES = `NV_WRITE_NS / `CLK_PERIOD_NS;
  localparam FW           = 19;
  localparam S_IDLE = 3'd0;
  localparam S_RX   = 3'd1;
  localparam S_ACK  = 3'd2;
  localparam S_TX   = 3'd3;
  localparam S_MACK = 3'd4;
  localparam PH_ADDR  = 2'd0;
  localparam PH_CMD   = 2'd1;
  localparam PH_MADDR = 2'd2;
  localparam PH_DATA  = 2'd3;

  // ****************************************************************
  // Pin synchronisers and bus condition detection
  // ****************************************************************
  reg  [3:0] in_meta_r;
  reg  [3:0] in_sync_r;
  reg        scl_prev_r;
  reg        sda_prev_r;
  wire       scl        = in_sync_r[3];
  wire       sda        = in_sync_r[2];
  wire       strap_high = in_sync_r[1];
  wire       strap_low  = in_sync_r[0];
  wire       scl_rise   = scl & ~scl_prev_r;
  wire       scl_fall   = ~scl & scl_prev_r;
  reg        start_hi_r;
  wire       start_det  = scl & scl_prev_r & sda_prev_r & ~sda;
  wire       stop_det   = scl & scl_prev_r & ~sda_prev_r & sda
                          & ~start_hi_r;

  always @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      in_meta_r  <= 4'hF;
      in_sync_r  <= 4'hF;
      scl_prev_r <= 1'b1;
      sda_prev_r <= 1'b1;
    end else begin
      in_meta_r  <= {scl_in, sda_in, addr_strap_high_in, addr_strap_low_in};
      in_sync_r  <= in_meta_r;
      scl_prev_r <= scl;
      sda_prev_r <= sda;
    end
  end

  // ****************************************************************
  // Protocol state
  // ****************************************************************
  reg  [2:0]    state_r;
  reg  [1:0]    phase_r;
  reg  [3:0]    cnt_r;
  reg  [7:0]    shift_r;
  reg  [7:0]    tx_r;
  reg  [7:0]    ptr_r;
  reg  [1:0]    page_r;
  reg           space_r;
  reg           rw_r;
  reg           ack_r;
  reg           reboot_pend_r;
  reg           rb_go_r;
  reg           push_r;
  reg  [FW-1:0] push_data_r;
  reg  [1:0]    fifo_cnt_r;
  reg           rb_active_r;
  reg           rb_wv_r;
  reg  [CNT_W-1:0] busy_cnt_r;
  wire [7:0]    vol_rdata;
  wire [7:0]    nv_rdata;
  wire          busy      = rb_active_r | rb_wv_r | (busy_cnt_r != 0);
  wire          fifo_room = (fifo_cnt_r != 2'd2);
  wire [7:0]    rd_byte   = space_r ? nv_rdata : vol_rdata;
  wire          addr_match = (shift_r[7:4] == `SLAVE_ID) &&
                             (shift_r[3] == strap_high) &&
                             (shift_r[2] == strap_low);
  wire          cmd_nv = (shift_r == `CMD_NV_CFG) ||
                         (shift_r == `CMD_NV_USR_A) ||
                         (shift_r == `CMD_NV_USR_B);
  reg           ack_ok;

  always @* begin
    ack_ok = 1'b0;
    case (phase_r)
      PH_ADDR:  ack_ok = ~busy;
      PH_CMD:   ack_ok = (shift_r <= `VOL_LAST) || cmd_nv ||
                         (shift_r == `CMD_BLOCK_RD) ||
                         (shift_r == `CMD_REBOOT);
      PH_MADDR: ack_ok = (page_r != `PAGE_CFG) ||
                         (shift_r <= `VOL_LAST);
      default:  ack_ok = fifo_room &&
                         ((space_r && page_r != `PAGE_CFG) ||
                          (ptr_r <= `VOL_LAST));
    endcase
  end

  always @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_r       <= S_IDLE;
      phase_r       <= PH_ADDR;
      cnt_r         <= 4'h0;
      shift_r       <= 8'h00;
      tx_r          <= 8'h00;
      ptr_r         <= 8'h00;
      page_r        <= `PAGE_CFG;
      space_r       <= 1'b0;
      rw_r          <= 1'b0;
      ack_r         <= 1'b0;
      reboot_pend_r <= 1'b0;
      rb_go_r       <= 1'b0;
      push_r        <= 1'b0;
      push_data_r   <= {FW{1'b0}};
      start_hi_r    <= 1'b0;
      sda_oe_out    <= 1'b0;
      sda_out       <= 1'b0;
    end else begin
      rb_go_r <= 1'b0;
      push_r  <= 1'b0;
      if (start_det) begin
        state_r       <= S_RX;
        phase_r       <= PH_ADDR;
        cnt_r         <= 4'h0;
        sda_oe_out    <= 1'b0;
        start_hi_r    <= 1'b1;
        reboot_pend_r <= 1'b0;
      end else if (stop_det) begin
        state_r       <= S_IDLE;
        sda_oe_out    <= 1'b0;
        reboot_pend_r <= 1'b0;
        rb_go_r       <= reboot_pend_r;
      end else begin
        if (scl_fall) begin
          start_hi_r <= 1'b0;
        end
        case (state_r)
          S_RX: begin
            if (scl_rise) begin
              shift_r <= {shift_r[6:0], sda};
              cnt_r   <= cnt_r + 4'h1;
            end else if (scl_fall && cnt_r == `BYTE_BITS) begin
              if (phase_r == PH_ADDR && !addr_match) begin
                state_r <= S_IDLE;
              end else begin
                state_r    <= S_ACK;
                ack_r      <= ack_ok;
                sda_oe_out <= ack_ok;
                if (ack_ok) begin
                  case (phase_r)
                    PH_ADDR: begin
                      rw_r    <= shift_r[0];
                      phase_r <= PH_CMD;
                    end
                    PH_CMD: begin
                      phase_r <= PH_DATA;
                      if (shift_r <= `VOL_LAST) begin
                        ptr_r   <= shift_r;
                        space_r <= 1'b0;
                      end else if (cmd_nv) begin
                        page_r  <= shift_r[1:0];
                        phase_r <= PH_MADDR;
                      end else if (shift_r == `CMD_REBOOT) begin
                        reboot_pend_r <= 1'b1;
                      end else begin
                        space_r <= 1'b0;
                      end
                    end
                    PH_MADDR: begin
                      ptr_r   <= shift_r;
                      space_r <= 1'b1;
                      phase_r <= PH_DATA;
                    end
                    default: begin
                      push_r      <= 1'b1;
                      push_data_r <= {space_r, page_r, ptr_r, shift_r};
                      ptr_r       <= ptr_r + 8'h01;
                      reboot_pend_r <= 1'b0;
                    end
                  endcase
                end
              end
            end
          end
          S_ACK: begin
            if (scl_fall) begin
              sda_oe_out <= 1'b0;
              cnt_r      <= 4'h0;
              if (!ack_r) begin
                state_r <= S_IDLE;
              end else if (rw_r && phase_r == PH_CMD) begin
                tx_r       <= rd_byte;
                sda_oe_out <= ~rd_byte[7];
                ptr_r      <= ptr_r + 8'h01;
                state_r    <= S_TX;
              end else begin
                state_r <= S_RX;
              end
            end
          end
          S_TX: begin
            if (scl_rise) begin
              cnt_r <= cnt_r + 4'h1;
            end else if (scl_fall) begin
              if (cnt_r == `BYTE_BITS) begin
                sda_oe_out <= 1'b0;
                state_r    <= S_MACK;
              end else begin
                sda_oe_out <= ~tx_r[6];
                tx_r       <= {tx_r[6:0], 1'b0};
              end
            end
          end
          S_MACK: begin
            if (scl_rise) begin
              cnt_r <= 4'h0;
              if (sda) begin
                state_r <= S_IDLE;
              end
            end else if (scl_fall) begin
              tx_r       <= rd_byte;
              sda_oe_out <= ~rd_byte[7];
              ptr_r      <= ptr_r + 8'h01;
              state_r    <= S_TX;
            end
          end
          default: begin
            sda_oe_out <= 1'b0;
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // Two-entry write buffer
  // ****************************************************************
  // The buffer lets a byte be accepted while a reload holds the memory
  // ports; when it is full the next data byte is refused rather than lost.
  reg  [FW-1:0] fifo_mem_r [0:1];
  reg           fifo_wp_r;
  reg           fifo_rp_r;
  wire          pop       = (fifo_cnt_r != 2'd0) & ~rb_active_r & ~rb_wv_r;
  wire          push_ok   = push_r & fifo_room;
  wire [FW-1:0] head      = fifo_mem_r[fifo_rp_r];
  wire          nv_we     = pop & head[18];
  wire          fifo_vwe  = pop & ~head[18];

  always @(posedge sys_clk_in) begin
    if (push_ok) begin
      fifo_mem_r[fifo_wp_r] <= push_data_r;
    end
  end

  always @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      fifo_wp_r  <= 1'b0;
      fifo_rp_r  <= 1'b0;
      fifo_cnt_r <= 2'd0;
    end else begin
      if (push_ok) begin
        fifo_wp_r <= ~fifo_wp_r;
      end
      if (pop) begin
        fifo_rp_r <= ~fifo_rp_r;
      end
      if (push_ok && !pop) begin
        fifo_cnt_r <= fifo_cnt_r + 2'd1;
      end else if (pop && !push_ok) begin
        fifo_cnt_r <= fifo_cnt_r - 2'd1;
      end
    end
  end

  // ****************************************************************
  // Reload sequencer, busy timer and output polarity
  // ****************************************************************
  reg  [6:0] rb_idx_r;
  reg  [6:0] rb_waddr_r;
  wire       vol_we    = rb_wv_r | fifo_vwe;
  wire [6:0] vol_waddr = rb_wv_r ? rb_waddr_r : head[14:8];
  wire [7:0] vol_wdata = rb_wv_r ? nv_rdata : head[7:0];
  wire [9:0] nv_raddr  = rb_active_r ? {3'b000, rb_idx_r}
                                     : {page_r, ptr_r};

  always @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rb_active_r  <= 1'b1;
      rb_idx_r     <= 7'h00;
      rb_wv_r      <= 1'b0;
      rb_waddr_r   <= 7'h00;
      busy_cnt_r   <= {CNT_W{1'b0}};
      busy_out     <= 1'b1;
      polarity_out <= `POL_FACTORY;
    end else begin
      rb_wv_r    <= rb_active_r;
      rb_waddr_r <= rb_idx_r;
      busy_out   <= busy;
      if (rb_active_r) begin
        rb_idx_r <= rb_idx_r + 7'h01;
        if (rb_idx_r == `VOL_LAST) begin
          rb_active_r <= 1'b0;
          busy_cnt_r  <= POWERUP_CYCLES[CNT_W-1:0];
        end
      end else if (rb_go_r) begin
        rb_active_r <= 1'b1;
        rb_idx_r    <= 7'h00;
      end else if (nv_we) begin
        busy_cnt_r <= NV_WR_CYCLES[CNT_W-1:0];
      end else if (busy_cnt_r != 0) begin
        busy_cnt_r <= busy_cnt_r - {{(CNT_W-1){1'b0}}, 1'b1};
      end
      if (vol_we && vol_waddr == `POL_ADDR) begin
        polarity_out <= vol_wdata;
      end
    end
  end

  config_mem #(
    .AW        (7),
    .DEPTH     (70),
    .INIT_ADDR (0),
    .INIT_VAL  (`NV_FACTORY)
  ) vol_bank (
    .sys_clk_in (sys_clk_in),
    .we_in      (vol_we),
    .waddr_in   (vol_waddr),
    .wdata_in   (vol_wdata),
    .raddr_in   (ptr_r[6:0]),
    .rdata_out  (vol_rdata)
  );

  config_mem #(
    .AW        (10),
    .DEPTH     (768),
    .INIT_ADDR (`POL_ADDR),
    .INIT_VAL  (`POL_FACTORY)
  ) nv_bank (
    .sys_clk_in (sys_clk_in),
    .we_in      (nv_we),
    .waddr_in   (head[17:8]),
    .wdata_in   (head[7:0]),
    .raddr_in   (nv_raddr),
    .rdata_out  (nv_rdata)
  );
endmodule // seq_i2c_slave

// File: seq_i2c_map.vh
`ifndef SEQ_I2C_MAP_VH
`define SEQ_I2C_MAP_VH
`define CLK_PERIOD_NS    10
`define POWERUP_DELAY_NS 3500000
`define NV_WRITE_NS      10000
`define SLAVE_ID         4'hA
`define BYTE_BITS        4'h8
`define VOL_LAST         8'h45
`define CMD_NV_CFG       8'h80
`define CMD_NV_USR_A     8'h81
`define CMD_NV_USR_B     8'h82
`define CMD_BLOCK_RD     8'h84
`define CMD_REBOOT       8'h88
`define POL_ADDR         8'h3A
`define POL_FACTORY      8'hFF
`define NV_FACTORY       8'h00
`define PAGE_CFG         2'h0
`endif

// File: config_mem.v
`timescale 1ns/1ps
`include "seq_i2c_map.vh"
module config_mem #(
  parameter AW        = 7,
  parameter DEPTH     = 70,
  parameter INIT_ADDR = 0,
  parameter INIT_VAL  = 8'h00
) (
  input  wire          sys_clk_in,
  input  wire          we_in,
  input  wire [AW-1:0] waddr_in,
  input  wire [7:0]    wdata_in,
  input  wire [AW-1:0] raddr_in,
  output reg  [7:0]    rdata_out
);
  reg [7:0] mem_r [0:DEPTH-1];
  integer i;

  // The array holds no reset so that its contents model retention; the
  // initial image stands for the shipped state.
  initial begin
    for (i = 0; i < DEPTH; i = i + 1) begin
      mem_r[i] = `NV_FACTORY;
    end
    mem_r[INIT_ADDR] = INIT_VAL;
  end

  always @(posedge sys_clk_in) begin
    if (we_in) begin
      mem_r[waddr_in] <= wdata_in;
    end
    rdata_out <= mem_r[raddr_in];
  end
endmodule // config_mem

// File: i2c_master_model.sv
`timescale 1ns/1ps
// ************************************************************
// Bus master model: makes the clock and frames every transfer.
// ************************************************************
module i2c_master_model (
  input  wire logic sys_clk_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      pull_out
);
  logic ph;
  initial begin
    scl_out = 1'b1;
    pull_out = 1'b0;
    ph = 1'b0;
  end
  // Counting falling edges keeps pin moves off the sampling edge.
  task automatic gap(input int n);
    repeat (n) @(negedge sys_clk_in);
  endtask
  // Lows of 6 and 7 cycles alternate to average a 125 ns period.
  task automatic bit_io(input logic b, output logic s);
    gap(3);
    pull_out = ~b;
    gap(3 + int'(ph));
    ph = ~ph;
    scl_out = 1'b1;
    gap(3);
    s = sda_in;
    gap(3);
    scl_out = 1'b0;
  endtask
  task automatic start;
    gap(3);
    pull_out = 1'b0;
    gap(3);
    scl_out = 1'b1;
    gap(3);
    pull_out = 1'b1;
    gap(3);
    scl_out = 1'b0;
  endtask
  task automatic stop;
    gap(3);
    pull_out = 1'b1;
    gap(3);
    scl_out = 1'b1;
    gap(3);
    pull_out = 1'b0;
    gap(6);
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], s);
    end
    bit_io(1'b1, s);
    ack = ~s;
  endtask
  task automatic rbyte(input logic mack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      b[i] = s;
    end
    bit_io(~mack, s);
  endtask
endmodule // i2c_master_model

// File: seq_i2c_monitor.sv
`timescale 1ns/1ps
module seq_i2c_monitor #(
  parameter POWERUP_CYCLES = 350000
) (
  input wire logic       sys_clk_in,
  input wire logic       rstn_in,
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe_out,
  input wire logic       busy_out,
  input wire logic [7:0] polarity_out
);
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rstn_in);
  logic [31:0] busy_cnt_r;
  always @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in)
      busy_cnt_r <= 32'h0;
    else
      busy_cnt_r <= busy_out ? busy_cnt_r + 32'h1 : 32'h0;
  end
  sequence start_seq;
    scl_in && $fell(sda_in);
  endsequence
  sequence ack_on_seq;
    $rose(sda_oe_out);
  endsequence
  // ************************************************************
  // Assertions
  // ************************************************************
  sda_drive_zero_a: assert property (
    sda_out == 1'b0) else $error("data pin driven high");
  oe_change_low_a: assert property (
    $changed(sda_oe_out) |-> !$past(scl_in))
    else $error("data drive moved while clock high");
  boot_busy_a: assert property (
    $rose(rstn_in) |-> busy_out [*8]) else $error("no boot delay");
  boot_polarity_a: assert property (
    $rose(rstn_in) |-> polarity_out == 8'hFF)
    else $error("polarity not all ones");
  busy_hold_a: assert property (
    $rose(busy_out) |-> busy_out [*8]) else $error("busy too short");
  busy_bound_a: assert property (
    busy_cnt_r < POWERUP_CYCLES + 2000) else $error("busy too long");
  ack_hold_a: assert property (
    ack_on_seq |-> sda_oe_out [*8]) else $error("drive too short");
  start_quiet_a: assert property (
    start_seq |-> !sda_oe_out [*8]) else $error("drive after start");
endmodule // seq_i2c_monitor

bind seq_i2c_slave seq_i2c_monitor #(
  .POWERUP_CYCLES(POWERUP_CYCLES)
) mon (
  .sys_clk_in   (sys_clk_in),
  .rstn_in      (rstn_in),
  .scl_in       (scl_in),
  .sda_in       (sda_in),
  .sda_out      (sda_out),
  .sda_oe_out   (sda_oe_out),
  .busy_out     (busy_out),
  .polarity_out (polarity_out)
);

// File: test_sequencer_i2c_slave_config_port.sv
`timescale 1ns/1ps
module test_sequencer_i2c_slave_config_port;
  logic            sys_clk = 1'b0;
  logic            rstn = 1'b0;
  logic            strap_high = 1'b1;
  logic            strap_low = 1'b0;
  wire logic       scl;
  wire logic       pull;
  wire logic       sda;
  wire logic       sda_drv;
  wire logic       sda_oe;
  wire logic       busy;
  wire logic [7:0] polarity;
  int              failures = 0;
  int              tests_run = 0;
  logic            ack;
  logic [7:0]      rd;
  localparam logic [7:0] cmd_table [8] =
    '{8'h00, 8'h45, 8'h80, 8'h81, 8'h82, 8'h84, 8'h46, 8'h83};
  // The pull-up wins unless some party pulls the line low.
  assign sda = !((sda_oe && !sda_drv) || pull);
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  seq_i2c_slave #(.POWERUP_CYCLES(200), .CNT_W(20)) dut (
    .sys_clk_in         (sys_clk),
    .rstn_in            (rstn),
    .scl_in             (scl),
    .sda_in             (sda),
    .addr_strap_high_in (strap_high),
    .addr_strap_low_in  (strap_low),
    .sda_out            (sda_drv),
    .sda_oe_out         (sda_oe),
    .busy_out           (busy),
    .polarity_out       (polarity)
  );
  i2c_master_model mst (
    .sys_clk_in (sys_clk),
    .sda_in     (sda),
    .scl_out    (scl),
    .pull_out   (pull)
  );
  task automatic check(input string what, input logic [7:0] e,
                       input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic summarize;
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 2000) begin
      @(negedge sys_clk);
      n++;
    end
    check("busy", 8'h00, {7'h0, busy});
  endtask
  task automatic xfer(input logic [7:0] b, input logic e, input string w);
    mst.wbyte(b, ack);
    check(w, {7'h0, e}, {7'h0, ack});
  endtask
  task automatic test_reset;
    check("reset polarity", 8'hFF, polarity);
    check("reset busy", 8'h01, {7'h0, busy});
    wait_idle();
    check("default polarity", 8'hFF, polarity);
    check("idle drive", 8'h00, {7'h0, sda_oe});
    check("drive value", 8'h00, {7'h0, sda_drv});
    $display("test reset done");
  endtask
  task automatic test_address;
    mst.start();
    xfer(8'hA4, 1'b0, "wrong strap ack");
    mst.stop();
    mst.start();
    xfer(8'hAA, 1'b1, "ignored bit ack");
    mst.stop();
    strap_high = 1'b0;
    strap_low  = 1'b1;
    mst.start();
    xfer(8'hA4, 1'b1, "swapped strap ack");
    mst.stop();
    mst.start();
    xfer(8'hA8, 1'b0, "old strap nack");
    mst.stop();
    strap_high = 1'b1;
    strap_low  = 1'b0;
    $display("test address done");
  endtask
  task automatic test_write_read;
    mst.start();
    xfer(8'hA8, 1'b1, "address ack");
    xfer(8'h3A, 1'b1, "command ack");
    xfer(8'h5A, 1'b1, "data ack");
    mst.stop();
    check("written polarity", 8'h5A, polarity);
    mst.start();
    xfer(8'hA8, 1'b1, "address ack");
    xfer(8'h3A, 1'b1, "command ack");
    mst.start();
    xfer(8'hA9, 1'b1, "read address ack");
    mst.rbyte(1'b0, rd);
    check("read back", 8'h5A, rd);
    mst.stop();
    $display("test write read done");
  endtask
  task automatic test_commands;
    for (int i = 0; i < 8; i++) begin
      mst.start();
      xfer(8'hA8, 1'b1, "address ack");
      xfer(cmd_table[i], i < 6, "command ack");
      mst.stop();
    end
    $display("test commands done");
  endtask
  task automatic test_reboot;
    mst.start();
    xfer(8'hA8, 1'b1, "address ack");
    xfer(8'h88, 1'b1, "reboot ack");
    mst.stop();
    repeat (3) @(negedge sys_clk);
    check("reboot busy", 8'h01, {7'h0, busy});
    mst.start();
    xfer(8'hA8, 1'b0, "busy address nack");
    mst.stop();
    wait_idle();
    check("reloaded polarity", 8'hFF, polarity);
    mst.start();
    xfer(8'hA8, 1'b1, "retry ack");
    mst.stop();
    $display("test reboot done");
  endtask
  task automatic nv_store(input logic [7:0] v);
    mst.start();
    xfer(8'hA8, 1'b1, "store address ack");
    xfer(8'h80, 1'b1, "store command ack");
    xfer(8'h3A, 1'b1, "store location ack");
    xfer(v, 1'b1, "store data ack");
    mst.stop();
  endtask
  task automatic reboot_now;
    mst.start();
    xfer(8'hA8, 1'b1, "address ack");
    xfer(8'h88, 1'b1, "reboot ack");
    mst.stop();
    wait_idle();
  endtask
  task automatic test_commit;
    nv_store(8'h5A);
    mst.start();
    xfer(8'hA8, 1'b0, "writing address nack");
    mst.stop();
    wait_idle();
    mst.start();
    xfer(8'hA8, 1'b1, "address ack");
    xfer(8'h80, 1'b1, "nv command ack");
    xfer(8'h46, 1'b0, "illegal location nack");
    mst.stop();
    mst.start();
    xfer(8'hA8, 1'b1, "address ack");
    xfer(8'h80, 1'b1, "nv command ack");
    xfer(8'h3A, 1'b1, "nv location ack");
    mst.start();
    xfer(8'hA9, 1'b1, "read address ack");
    mst.rbyte(1'b0, rd);
    check("nv read back", 8'h5A, rd);
    mst.stop();
    reboot_now();
    check("committed polarity", 8'h5A, polarity);
    nv_store(8'h00);
    wait_idle();
    reboot_now();
    check("cleared polarity", 8'h00, polarity);
    $display("test commit done");
  endtask
  initial begin
    #300000;
    failures++;
    summarize();
  end
  initial begin
    repeat (8) @(negedge sys_clk);
    rstn = 1'b1;
    @(negedge sys_clk);
    test_reset();
    test_address();
    test_write_read();
    test_commands();
    test_reboot();
    test_commit();
    summarize();
  end
endmodule // test_sequencer_i2c_slave_config_port
